// [inc/irq_bank_pkg.sv]
package irq_bank_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_ENABLE_2   = 8'h00;
    localparam logic [7:0] OFS_ENABLE_3   = 8'h04;
    localparam logic [7:0] OFS_ENABLE_4   = 8'h08;
    localparam logic [7:0] OFS_PRIORITY_0 = 8'h0C;
    localparam logic [7:0] OFS_PRIORITY_1 = 8'h10;
    localparam logic [7:0] OFS_PRIORITY_2 = 8'h14;
    localparam logic [7:0] OFS_STATUS     = 8'h18;
    localparam logic [7:0] OFS_MASK       = 8'h1C;

    // Implemented bits of the enable and priority registers; all others read as zero.
    localparam logic [15:0] MASK_ENABLE_2  = 16'h0007;
    localparam logic [15:0] MASK_ENABLE_3  = 16'h39FF;
    localparam logic [15:0] MASK_ENABLE_4  = 16'h00F6;
    localparam logic [15:0] MASK_PRIORITY  = 16'h7777;

    // Values after reset.
    localparam logic [15:0] RST_ENABLE     = 16'h0000;
    localparam logic [15:0] RST_PRIORITY   = 16'h4444;
    localparam logic [2:0]  RST_EVENTS     = 3'h0;

    // Source counts and level coding.
    localparam int unsigned NUM_EN_SRC     = 21;
    localparam int unsigned NUM_PRI_SRC    = 12;
    localparam int unsigned LEVEL_W        = 3;
    localparam logic [2:0]  LEVEL_OFF      = 3'h0;
    localparam logic [2:0]  LEVEL_TOP      = 3'h7;

    // Event bits of the status and mask registers.
    localparam int unsigned EVT_W          = 3;
    localparam int unsigned EVT_NEW_REQ    = 0;
    localparam int unsigned EVT_TOP_LEVEL  = 1;
    localparam int unsigned EVT_BAD_ADDR   = 2;

    // Data phase of the bus slave.
    typedef enum logic [1:0] {
        PH_IDLE      = 2'h0,
        PH_READ_WAIT = 2'h1,
        PH_READ_DONE = 2'h3,
        PH_WRITE     = 2'h2
    } phase_t;

    // Picks the 3-bit level field of a given slot out of a priority word.
    function automatic logic [2:0] field_of(input logic [15:0] word,
                                            input logic [1:0]  slot);
        return word[{slot, 2'b00} +: 3];
    endfunction : field_of

endpackage : irq_bank_pkg

// [logic/irq_enable_priority_bank.sv]
// Behaviour
// - enable bit one passes, zero blocks request
// - priority field three bits, 111 is seven
// - priority 000 removes source from arbitration
// - 001 lowest level, values in order
// - unimplemented bits read zero, ignore writes
// - priority fields reset to level four
// - enable 2 bits: CAN1 rx, SPI2
// - enable 3 upper bits: DMA5, codec, CAN2
// - enable 3 low bits: ext, timers, I2C2
// - enable 4 bits: CAN tx, DMA, UART
// - priority 0: timer1, compare1, capture1, ext0
// - priority 1: timer2, compare2, capture2, DMA0
// - priority 2: UART1 rx, SPI1, timer3
// - flag set means request has occurred
`timescale 1ns/10ps
module irq_enable_priority_bank
    import irq_bank_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk,
    input  wire logic                    rst,
    // AHB-Lite slave.
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // Sources gated by enable bits held here.
    input  wire logic [NUM_EN_SRC-1:0]   en_src_flag,
    input  wire logic [NUM_EN_SRC-1:0]   en_src_level_nz,
    output logic      [NUM_EN_SRC-1:0]   en_src_req,
    // Sources ranked by priority fields held here.
    input  wire logic [NUM_PRI_SRC-1:0]  pri_src_flag,
    input  wire logic [NUM_PRI_SRC-1:0]  pri_src_enable,
    output logic      [NUM_PRI_SRC-1:0]  pri_src_req,
    output logic      [NUM_PRI_SRC*3-1:0] pri_src_level,
    // Interrupt to the system.
    output logic                         irq
);

    // Register state.
    logic [15:0]         irq_enable_ctrl_2;
    logic [15:0]         irq_enable_ctrl_3;
    logic [15:0]         irq_enable_ctrl_4;
    logic [15:0]         irq_priority_ctrl_0;
    logic [15:0]         irq_priority_ctrl_1;
    logic [15:0]         irq_priority_ctrl_2;
    logic [EVT_W-1:0]    evt_status;
    logic [EVT_W-1:0]    evt_mask;

    // Bus data phase state.
    phase_t              phase;
    phase_t              next_phase;
    logic [7:0]          d_addr;

    // Address phase decode.
    logic                take;
    logic                addr_mapped;
    logic                wr_phase;
    assign take        = hsel & hready & htrans[1];
    assign addr_mapped = (haddr == OFS_ENABLE_2) | (haddr == OFS_ENABLE_3) |
                         (haddr == OFS_ENABLE_4) | (haddr == OFS_PRIORITY_0) |
                         (haddr == OFS_PRIORITY_1) | (haddr == OFS_PRIORITY_2) |
                         (haddr == OFS_STATUS) | (haddr == OFS_MASK);
    assign wr_phase    = (phase == PH_WRITE);

    // Reads take one wait state so that hrdata comes from a flip-flop.
    assign next_phase = (phase == PH_READ_WAIT) ? PH_READ_DONE :
                        !take                   ? PH_IDLE :
                        hwrite                  ? PH_WRITE : PH_READ_WAIT;
    assign hreadyout  = (phase != PH_READ_WAIT);
    assign hresp      = 1'b0;

    // Phase and captured address.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase  <= PH_IDLE;
            d_addr <= 8'h00;
        end else begin
            phase <= next_phase;
            if (take) begin
                d_addr <= haddr;
            end
        end
    end

    // Write strobes for each register, taken in the write data phase.
    logic we_en2;
    logic we_en3;
    logic we_en4;
    logic we_pr0;
    logic we_pr1;
    logic we_pr2;
    logic we_stat;
    logic we_mask;
    assign we_en2  = wr_phase & (d_addr == OFS_ENABLE_2);
    assign we_en3  = wr_phase & (d_addr == OFS_ENABLE_3);
    assign we_en4  = wr_phase & (d_addr == OFS_ENABLE_4);
    assign we_pr0  = wr_phase & (d_addr == OFS_PRIORITY_0);
    assign we_pr1  = wr_phase & (d_addr == OFS_PRIORITY_1);
    assign we_pr2  = wr_phase & (d_addr == OFS_PRIORITY_2);
    assign we_stat = wr_phase & (d_addr == OFS_STATUS);
    assign we_mask = wr_phase & (d_addr == OFS_MASK);

    // Enable registers; masking on write keeps unused bits at zero.
    // mask on write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable_ctrl_2 <= RST_ENABLE;
            irq_enable_ctrl_3 <= RST_ENABLE;
            irq_enable_ctrl_4 <= RST_ENABLE;
        end else begin
            if (we_en2) irq_enable_ctrl_2 <= hwdata[15:0] & MASK_ENABLE_2;
            if (we_en3) irq_enable_ctrl_3 <= hwdata[15:0] & MASK_ENABLE_3;
            if (we_en4) irq_enable_ctrl_4 <= hwdata[15:0] & MASK_ENABLE_4;
        end
    end

    // Priority registers, every field back at level four after reset.
    // priority reset value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_priority_ctrl_0 <= RST_PRIORITY;
            irq_priority_ctrl_1 <= RST_PRIORITY;
            irq_priority_ctrl_2 <= RST_PRIORITY;
        end else begin
            if (we_pr0) irq_priority_ctrl_0 <= hwdata[15:0] & MASK_PRIORITY;
            if (we_pr1) irq_priority_ctrl_1 <= hwdata[15:0] & MASK_PRIORITY;
            if (we_pr2) irq_priority_ctrl_2 <= hwdata[15:0] & MASK_PRIORITY;
        end
    end

    // Named enable bits.
    // enable 2 map
    logic can1_rx_ready_irq_en;
    logic spi2_event_irq_en;
    logic spi2_error_irq_en;
    assign can1_rx_ready_irq_en = irq_enable_ctrl_2[2];
    assign spi2_event_irq_en    = irq_enable_ctrl_2[1];
    assign spi2_error_irq_en    = irq_enable_ctrl_2[0];

    logic dma_ch5_done_irq_en;
    logic codec_if_event_irq_en;
    logic codec_if_error_irq_en;
    logic can2_event_irq_en;
    logic can2_rx_ready_irq_en;
    assign dma_ch5_done_irq_en   = irq_enable_ctrl_3[13];
    assign codec_if_event_irq_en = irq_enable_ctrl_3[12];
    assign codec_if_error_irq_en = irq_enable_ctrl_3[11];
    assign can2_event_irq_en     = irq_enable_ctrl_3[8];
    assign can2_rx_ready_irq_en  = irq_enable_ctrl_3[7];

    logic ext_irq4_en;
    logic ext_irq3_en;
    logic timer9_irq_en;
    logic timer8_irq_en;
    logic i2c2_master_irq_en;
    logic i2c2_slave_irq_en;
    logic timer7_irq_en;
    assign ext_irq4_en        = irq_enable_ctrl_3[6];
    assign ext_irq3_en        = irq_enable_ctrl_3[5];
    assign timer9_irq_en      = irq_enable_ctrl_3[4];
    assign timer8_irq_en      = irq_enable_ctrl_3[3];
    assign i2c2_master_irq_en = irq_enable_ctrl_3[2];
    assign i2c2_slave_irq_en  = irq_enable_ctrl_3[1];
    assign timer7_irq_en      = irq_enable_ctrl_3[0];

    logic can2_tx_request_irq_en;
    logic can1_tx_request_irq_en;
    logic dma_ch7_done_irq_en;
    logic dma_ch6_done_irq_en;
    logic uart2_error_irq_en;
    logic uart1_error_irq_en;
    assign can2_tx_request_irq_en = irq_enable_ctrl_4[7];
    assign can1_tx_request_irq_en = irq_enable_ctrl_4[6];
    assign dma_ch7_done_irq_en    = irq_enable_ctrl_4[5];
    assign dma_ch6_done_irq_en    = irq_enable_ctrl_4[4];
    assign uart2_error_irq_en     = irq_enable_ctrl_4[2];
    assign uart1_error_irq_en     = irq_enable_ctrl_4[1];

    // Enable vector, index 0 is the lowest bit of enable register 2.
    logic [NUM_EN_SRC-1:0] en_vec;
    assign en_vec = {uart1_error_irq_en, uart2_error_irq_en, dma_ch6_done_irq_en,
                     dma_ch7_done_irq_en, can1_tx_request_irq_en,
                     can2_tx_request_irq_en, dma_ch5_done_irq_en,
                     codec_if_event_irq_en, codec_if_error_irq_en,
                     can2_event_irq_en, can2_rx_ready_irq_en, ext_irq4_en,
                     ext_irq3_en, timer9_irq_en, timer8_irq_en,
                     i2c2_master_irq_en, i2c2_slave_irq_en, timer7_irq_en,
                     can1_rx_ready_irq_en, spi2_event_irq_en, spi2_error_irq_en};

    // Level fields, four slots to a word, slot 0 in the lowest bits.
    // priority 0 map
    logic [2:0][15:0] pri_words;
    logic [NUM_PRI_SRC-1:0] lvl_nz;
    logic [NUM_PRI_SRC-1:0] lvl_top;
    assign pri_words = {irq_priority_ctrl_2, irq_priority_ctrl_1, irq_priority_ctrl_0};
    for (genvar k = 0; k < NUM_PRI_SRC; k++) begin : g_level
        assign pri_src_level[k*3 +: 3] = field_of(pri_words[k/4], 2'(k % 4));
        assign lvl_nz[k]  = (field_of(pri_words[k/4], 2'(k % 4)) != LEVEL_OFF);
        assign lvl_top[k] = (field_of(pri_words[k/4], 2'(k % 4)) == LEVEL_TOP);
    end

    // Named level fields for the twelve ranked sources.
    logic [2:0] ext_irq0_level;
    logic [2:0] in_capture1_irq_level;
    logic [2:0] out_compare1_irq_level;
    logic [2:0] timer1_irq_level;
    logic [2:0] dma_ch0_done_irq_level;
    logic [2:0] in_capture2_irq_level;
    logic [2:0] out_compare2_irq_level;
    logic [2:0] timer2_irq_level;
    logic [2:0] timer3_irq_level;
    logic [2:0] spi1_error_irq_level;
    logic [2:0] spi1_event_irq_level;
    logic [2:0] uart1_rx_irq_level;
    assign ext_irq0_level         = pri_src_level[2:0];
    assign in_capture1_irq_level  = pri_src_level[5:3];
    assign out_compare1_irq_level = pri_src_level[8:6];
    assign timer1_irq_level       = pri_src_level[11:9];
    assign dma_ch0_done_irq_level = pri_src_level[14:12];
    assign in_capture2_irq_level  = pri_src_level[17:15];
    assign out_compare2_irq_level = pri_src_level[20:18];
    assign timer2_irq_level       = pri_src_level[23:21];
    assign timer3_irq_level       = pri_src_level[26:24];
    assign spi1_error_irq_level   = pri_src_level[29:27];
    assign spi1_event_irq_level   = pri_src_level[32:30];
    assign uart1_rx_irq_level     = pri_src_level[35:33];

    // Gating toward arbitration; a source needs flag, enable and level.
    // enable gates request
    logic [NUM_EN_SRC-1:0]  next_en_req;
    logic [NUM_PRI_SRC-1:0] next_pri_req;
    assign next_en_req  = en_src_flag & en_vec & en_src_level_nz;
    assign next_pri_req = pri_src_flag & pri_src_enable & lvl_nz;

    // Requests are registered so the core sees a clean level.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_src_req  <= '0;
            pri_src_req <= '0;
        end else begin
            en_src_req  <= next_en_req;
            pri_src_req <= next_pri_req;
        end
    end

    // Sticky events; a new event beats a clear in the same cycle.
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [EVT_W-1:0] next_status;
    assign evt_set[EVT_NEW_REQ]   = |(next_en_req & ~en_src_req) |
                                    |(next_pri_req & ~pri_src_req);
    assign evt_set[EVT_TOP_LEVEL] = |(next_pri_req & lvl_top & ~pri_src_req);
    assign evt_set[EVT_BAD_ADDR]  = take & ~addr_mapped;
    assign evt_clr     = we_stat ? hwdata[EVT_W-1:0] : '0;
    assign next_status = (evt_status & ~evt_clr) | evt_set;

    // Status and mask registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_status <= RST_EVENTS;
            evt_mask   <= RST_EVENTS;
        end else begin
            evt_status <= next_status;
            if (we_mask) evt_mask <= hwdata[EVT_W-1:0];
        end
    end

    assign irq = |(evt_status & evt_mask);

    // Read selection; unmapped offsets read as zero.
    // unused bits zero
    logic [15:0] rd_word;
    assign rd_word = (d_addr == OFS_ENABLE_2)   ? irq_enable_ctrl_2 :
                     (d_addr == OFS_ENABLE_3)   ? irq_enable_ctrl_3 :
                     (d_addr == OFS_ENABLE_4)   ? irq_enable_ctrl_4 :
                     (d_addr == OFS_PRIORITY_0) ? irq_priority_ctrl_0 :
                     (d_addr == OFS_PRIORITY_1) ? irq_priority_ctrl_1 :
                     (d_addr == OFS_PRIORITY_2) ? irq_priority_ctrl_2 :
                     (d_addr == OFS_STATUS)     ? {13'h0000, evt_status} :
                     (d_addr == OFS_MASK)       ? {13'h0000, evt_mask} : 16'h0000;

    // Read data is loaded during the wait state and held until the next read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (phase == PH_READ_WAIT) begin
            hrdata <= {16'h0000, rd_word};
        end
    end

    // Checks on the outputs and registers.
    en_block_a: assert property (
        @(posedge clk) disable iff (rst)
        (en_src_req & ~$past(en_vec)) == '0)
        else $error("Request passed with its enable clear.");

    top_level_a: assert property (
        @(posedge clk) disable iff (rst)
        we_pr0 && hwdata[14:12] == 3'h7 |=> timer1_irq_level == LEVEL_TOP)
        else $error("Field 111 did not give level seven.");

    zero_level_a: assert property (
        @(posedge clk) disable iff (rst)
        (pri_src_req & ~$past(lvl_nz)) == '0)
        else $error("Source at level zero reached arbitration.");

    low_level_a: assert property (
        @(posedge clk) disable iff (rst)
        we_pr2 && hwdata[2:0] == 3'h1 |=> timer3_irq_level == 3'h1)
        else $error("Field 001 did not give level one.");

    unused_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        phase == PH_READ_DONE && d_addr == OFS_ENABLE_4 |-> hrdata[31:8] == '0
            && hrdata[3] == 1'b0 && hrdata[0] == 1'b0)
        else $error("Unimplemented bit read as one.");

    en_reset_a: assert property (
        @(posedge clk) rst |-> en_vec == '0)
        else $error("Enable bit set under reset.");

    pri_reset_a: assert property (
        @(posedge clk) rst |-> pri_src_level == {NUM_PRI_SRC{3'h4}})
        else $error("Priority field not level four under reset.");

    en2_map_a: assert property (
        @(posedge clk) disable iff (rst)
        we_en2 && hwdata[2:0] == 3'h4 |=> en_vec[2:0] == 3'h4 ##1 en_src_req[1:0] == 2'h0)
        else $error("Enable register 2 bits mapped wrongly.");

    en4_map_a: assert property (
        @(posedge clk) disable iff (rst)
        we_en4 |=> irq_enable_ctrl_4 == ($past(hwdata[15:0]) & MASK_ENABLE_4))
        else $error("Enable register 4 kept an unimplemented bit.");

    pri0_map_a: assert property (
        @(posedge clk) disable iff (rst)
        we_pr0 |=> ext_irq0_level == $past(hwdata[2:0])
            && out_compare1_irq_level == $past(hwdata[10:8]))
        else $error("Priority register 0 fields mapped wrongly.");

    flag_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        (pri_src_req & ~$past(pri_src_flag)) == '0)
        else $error("Request without its flag.");

    three_gate_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(en_src_req[0]) |-> $past(en_src_flag[0] && spi2_error_irq_en
            && en_src_level_nz[0]))
        else $error("Request rose without all three conditions.");

    set_wins_a: assert property (
        @(posedge clk) disable iff (rst)
        evt_set[EVT_BAD_ADDR] |=> evt_status[EVT_BAD_ADDR])
        else $error("Event lost against a clear.");

endmodule : irq_enable_priority_bank

// [tb/core_arb_model.sv]
`timescale 1ns/10ps
module core_arb_model
    import irq_bank_pkg::*;
(
    // Ranked requests from the bank.
    input  wire logic [NUM_PRI_SRC-1:0]   pri_src_req,
    input  wire logic [NUM_PRI_SRC*3-1:0] pri_src_level,
    // Arbitration result.
    output logic      [2:0]               best_level
);
    // The core takes the highest presented level; an unpresented source never wins.
    // level ordering
    always_comb begin
        best_level = LEVEL_OFF;
        for (int k = 0; k < NUM_PRI_SRC; k++) begin
            if (pri_src_req[k] && pri_src_level[3*k +: 3] > best_level) begin
                best_level = pri_src_level[3*k +: 3];
            end
        end
    end
endmodule : core_arb_model

// [tb/test_irq_enable_priority_bank.sv]
`timescale 1ns/10ps
module test_irq_enable_priority_bank
    import irq_bank_pkg::*;
;
    logic        clk, rst, hsel, hwrite, hresp, hreadyout, irq;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, best;
    logic [31:0] hwdata, hrdata, rd;
    logic [20:0] en_flag, en_nz, en_req;
    logic [11:0] pri_flag, pri_en, pri_req;
    logic [35:0] pri_lvl;
    int          error_cnt, num_checks;
    logic [15:0] msk [6] = '{16'h0007, 16'h39FF, 16'h00F6, 16'h7777, 16'h7777, 16'h7777};

    irq_enable_priority_bank irq_enable_priority_bank_i (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .en_src_flag(en_flag), .en_src_level_nz(en_nz), .en_src_req(en_req),
        .pri_src_flag(pri_flag), .pri_src_enable(pri_en), .pri_src_req(pri_req),
        .pri_src_level(pri_lvl), .irq(irq)
    );

    core_arb_model core_arb_model_i (
        .pri_src_req(pri_req), .pri_src_level(pri_lvl), .best_level(best)
    );

    // Free-running system clock.
    always #5 clk = ~clk;

    // Cuts a hung run short well after the tests should have ended.
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Steps edge by edge until ready is sampled high; values seen here are those before the edge.
    task automatic to_ready_edge(output logic [31:0] d);
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
        end
        d = hrdata;
    endtask : to_ready_edge

    // One single word transfer: address phase, then data phase, both driven from an edge.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        to_ready_edge(rd);
        htrans <= 2'b00;
        hwdata <= wd;
        to_ready_edge(rd);
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
        chk(hresp, 1'b0);
    endtask : rd_chk

    // Requests follow one edge late; two edges leave margin.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Source order of the enable-gated request vector.
    function automatic logic [20:0] en_exp(logic [15:0] e2, logic [15:0] e3, logic [15:0] e4);
        return {e4[1], e4[2], e4[4], e4[5], e4[6], e4[7], e3[13:11], e3[8:0], e2[2:0]};
    endfunction : en_exp

    // Fields sit on a four-bit stride, three bits used.
    function automatic logic [35:0] lvl_exp(logic [47:0] p);
        for (int k = 0; k < 12; k++) lvl_exp[3*k +: 3] = p[4*k +: 3];
    endfunction : lvl_exp

    function automatic logic [11:0] req_exp(logic [35:0] l);
        for (int k = 0; k < 12; k++) req_exp[k] = pri_flag[k] & pri_en[k] & (l[3*k +: 3] != 3'h0);
    endfunction : req_exp

    // Main sequence of tests.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = 32'h0;
        en_flag = '1;
        en_nz = '1;
        pri_flag = '0;
        pri_en = '1;
        error_cnt = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rd_chk(8'(4*i), (i >= 3 && i <= 5) ? 32'h4444 : 32'h0);
        chk(pri_lvl, 36'h924924924);
        chk(en_req, 21'h0);
        $display("test reset values done");

        for (int i = 0; i < 6; i++) begin
            wr(8'(4*i), 32'hFFFFFFFF);
            rd_chk(8'(4*i), {16'h0, msk[i]});
        end
        settle();
        chk(en_req, 21'h1FFFFF);
        wr(OFS_ENABLE_2, 32'h4);
        wr(OFS_ENABLE_3, 32'h2901);
        wr(OFS_ENABLE_4, 32'hA2);
        @(posedge clk);
        en_nz <= 21'h17FFFF;
        settle();
        chk(en_req, en_exp(16'h4, 16'h2901, 16'hA2) & 21'h17FFFF);
        $display("test enable gating done");

        @(posedge clk);
        pri_flag <= '1;
        wr(OFS_PRIORITY_0, 32'h7310);
        wr(OFS_PRIORITY_1, 32'h0246);
        wr(OFS_PRIORITY_2, 32'h5021);
        settle();
        chk(pri_lvl, lvl_exp(48'h5021_0246_7310));
        chk(pri_req, req_exp(lvl_exp(48'h5021_0246_7310)));
        chk(best, 3'h7);
        $display("test priority fields done");

        wr(OFS_STATUS, 32'h7);
        wr(OFS_MASK, 32'h3);
        rd_chk(OFS_STATUS, 32'h0);
        chk(irq, 1'b0);
        @(posedge clk);
        pri_flag <= '0;
        settle();
        @(posedge clk);
        pri_flag <= '1;
        settle();
        rd_chk(OFS_STATUS, 32'h3);
        chk(irq, 1'b1);
        wr(OFS_STATUS, 32'h3);
        chk(irq, 1'b0);
        wr(8'h40, 32'hFFFF);
        rd_chk(8'h40, 32'h0);
        rd_chk(OFS_STATUS, 32'h4);
        chk(irq, 1'b0);
        wr(OFS_MASK, 32'h7);
        chk(irq, 1'b1);
        wr(OFS_STATUS, 32'h4);
        chk(irq, 1'b0);
        $display("test interrupt status done");

        wr(OFS_PRIORITY_0, 32'h0310);
        settle();
        chk(pri_req[3], 1'b0);
        chk(best, 3'h6);
        $display("test level zero done");
        end_sim();
    end
endmodule : test_irq_enable_priority_bank
